// File: design/bank_if.sv
`timescale 1ns/1ps
interface bank_if;
	logic wr_en;
	logic [31:0] wr_data;
	logic [31:0] wr_keep;
	logic [31:0] rd_data;
	modport owner (output wr_en, output wr_data, output wr_keep, input rd_data);
	modport store (input wr_en, input wr_data, input wr_keep, output rd_data);
endinterface

// File: design/shcs_defs.svh
`ifndef SHCS_DEFS_SVH
`define SHCS_DEFS_SVH
// register byte offsets inside the block's APB window
`define SHCS_OFF_STATE 12'h000
`define SHCS_OFF_CFG 12'h004
`define SHCS_OFF_EVT 12'h008
`define SHCS_OFF_MASK 12'h00C
// bit positions of the handler state word
`define B_HF_PEND 21
`define B_SF_PEND 20
`define B_SF_EN 19
`define B_UF_EN 18
`define B_BF_EN 17
`define B_MM_EN 16
`define B_SVC_PEND 15
`define B_BF_PEND 14
`define B_MM_PEND 13
`define B_UF_PEND 12
`define B_TICK_ACT 11
`define B_PSV_ACT 10
`define B_MON_ACT 8
`define B_SVC_ACT 7
`define B_NMI_ACT 5
`define B_SF_ACT 4
`define B_UF_ACT 3
`define B_HF_ACT 2
`define B_BF_ACT 1
`define B_MM_ACT 0
// field masks
`define M_IMPL 32'h003FFDBF
`define M_SEC_ONLY 32'h00180010
`define M_SHARED 32'h001A4132
`define M_BUS 32'h00024002
`define STATE_RST 32'h00000000
// config word bits
`define C_BF_NS 0
`define C_SEC_EXT 1
`endif

// File: design/shcs_pkg.sv
package shcs_pkg;
	typedef enum logic [1:0] {
		F_MEM = 2'b00,
		F_BUS = 2'b01,
		F_USAGE = 2'b10,
		F_SEC = 2'b11
	} fault_kind_t;
	typedef enum logic [0:0] {
		APB_SETUP = 1'b0,
		APB_ACCESS = 1'b1
	} apb_phase_t;
endpackage

// File: design/state_bank.sv
`timescale 1ns/1ps
`include "shcs_defs.svh"
// one copy of the handler state word; only bits in wr_keep change on write
module state_bank (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	bank_if.store bus
);
	logic [31:0] word_q;
	// ********************
	// storage
	// ********************
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			word_q <= `STATE_RST;
		end else if (bus.wr_en) begin
			word_q <= (word_q & ~bus.wr_keep) | (bus.wr_data & bus.wr_keep);
		end
	end
	assign bus.rd_data = word_q;
endmodule

// File: design/system_handler_control_state.sv
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "shcs_defs.svh"
module system_handler_control_state
	import shcs_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [2:0] pprot,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fault_valid_i,
	input wire fault_kind_t fault_kind_i,
	input wire logic fault_secure_i,
	output logic fault_take_o,
	output fault_kind_t fault_take_kind_o,
	output logic hard_fault_o,
	output logic hf_preempt_s_o,
	output logic hf_preempt_ns_o,
	output logic irq_o
);
	// ********************
	// configuration and bus decode
	// ********************
	logic [1:0] cfg_q;
	logic [1:0] evt_q;
	logic [1:0] mask_q;
	logic sec_ext;
	logic bf_ns;
	logic ns_acc;
	logic acc;
	logic wr;
	logic hit_state, hit_cfg, hit_evt, hit_mask, hit_any;
	logic [31:0] rd_view;
	logic [31:0] wr_ok;
	logic [31:0] impl;

	assign sec_ext = cfg_q[`C_SEC_EXT];
	assign bf_ns = cfg_q[`C_BF_NS];
	assign ns_acc = pprot[1] & sec_ext;
	assign acc = psel & penable;
	assign wr = acc & pwrite & (&pstrb);
	assign hit_state = paddr == `SHCS_OFF_STATE;
	assign hit_cfg = paddr == `SHCS_OFF_CFG;
	assign hit_evt = paddr == `SHCS_OFF_EVT;
	assign hit_mask = paddr == `SHCS_OFF_MASK;
	assign hit_any = hit_state | hit_cfg | hit_evt | hit_mask;
	assign pready = 1'b1;
	assign pslverr = acc & ~hit_any;

	// secure fault bits exist only with the extension
	assign impl = sec_ext ? `M_IMPL : (`M_IMPL & ~`M_SEC_ONLY);

	// combined view of the two banks as the current requester sees it
	function automatic logic [31:0] view(input logic [31:0] own, input logic [31:0] shared, input logic ns,
		input logic bfns, input logic [31:0] im);
		logic [31:0] v;
		v = (own & ~`M_SHARED) | (shared & `M_SHARED);
		if (ns && !bfns) begin
			v = v & ~`M_BUS;
		end
		return v & im;
	endfunction

	// ********************
	// banked storage
	// ********************
	bank_if sec_b ();
	bank_if ns_b ();
	state_bank u_sec (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus(sec_b));
	state_bank u_ns (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus(ns_b));

	// shared bits live in the secure copy; writes follow the requester's view
	assign wr_ok = impl & ~((ns_acc & ~bf_ns) ? `M_BUS : 32'h00000000);
	assign rd_view = view(ns_acc ? ns_b.rd_data : sec_b.rd_data, sec_b.rd_data, ns_acc, bf_ns, impl);
	assign sec_b.wr_en = wr & hit_state;
	assign sec_b.wr_data = pwdata;
	assign sec_b.wr_keep = ns_acc ? (wr_ok & `M_SHARED) : wr_ok;
	assign ns_b.wr_en = wr & hit_state & ns_acc;
	assign ns_b.wr_data = pwdata;
	assign ns_b.wr_keep = wr_ok & ~`M_SHARED;

	// ********************
	// fault escalation
	// ********************
	logic [31:0] cur;
	logic en_bit;
	logic [4:0] en_pos;
	assign cur = view(fault_secure_i ? sec_b.rd_data : ns_b.rd_data, sec_b.rd_data, 1'b0, 1'b1, impl);
	always_comb begin
		unique case (fault_kind_i)
			F_MEM: en_pos = 5'(`B_MM_EN);
			F_BUS: en_pos = 5'(`B_BF_EN);
			F_USAGE: en_pos = 5'(`B_UF_EN);
			F_SEC: en_pos = 5'(`B_SF_EN);
		endcase
	end
	assign en_bit = cur[en_pos];

	// disabled handlers turn the fault into a hard fault
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			fault_take_o <= 1'b0;
			hard_fault_o <= 1'b0;
			fault_take_kind_o <= F_MEM;
		end else begin
			fault_take_o <= fault_valid_i & en_bit;
			hard_fault_o <= fault_valid_i & ~en_bit;
			fault_take_kind_o <= fault_kind_i;
		end
	end

	// hard fault pended: non-secure one only preempts when delegated
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			hf_preempt_s_o <= 1'b0;
			hf_preempt_ns_o <= 1'b0;
		end else begin
			hf_preempt_s_o <= sec_b.rd_data[`B_HF_PEND];
			hf_preempt_ns_o <= sec_ext & bf_ns & ns_b.rd_data[`B_HF_PEND];
		end
	end

	// ********************
	// configuration, events and mask
	// ********************
	// config only changes from the secure side
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			cfg_q <= 2'h0;
		end else if (wr && hit_cfg && !ns_acc) begin
			cfg_q <= pwdata[1:0];
		end
	end

	// event 0 escalation, event 1 non-secure preemption blocked, both gated by mask_q at irq_o; set beats clear
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			evt_q <= 2'h0;
		end else begin
			evt_q <= (evt_q & ~((wr && hit_evt) ? pwdata[1:0] : 2'h0))
				| {sec_ext & ~bf_ns & ns_b.rd_data[`B_HF_PEND], fault_valid_i & ~en_bit};
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			mask_q <= 2'h0;
		end else if (wr && hit_mask) begin
			mask_q <= pwdata[1:0];
		end
	end

	assign irq_o = |(evt_q & mask_q);

	// read data register
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			unique case (1'b1)
				hit_state: prdata <= rd_view;
				hit_cfg: prdata <= {30'h0, cfg_q};
				hit_evt: prdata <= {30'h0, evt_q};
				hit_mask: prdata <= {30'h0, mask_q};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// ********************
	// checks
	// ********************
	chk_escalate_hard: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		fault_valid_i && !en_bit |=> hard_fault_o && !fault_take_o) else $error("disabled fault not escalated");
	chk_enable_take: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		fault_valid_i && en_bit |=> fault_take_o && !hard_fault_o) else $error("enabled fault escalated");
	chk_bus_hidden: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		ns_acc && !bf_ns |-> (rd_view & `M_BUS) == 32'h0) else $error("bus bits visible to non-secure");
	chk_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(rd_view & ~impl) == 32'h0) else $error("reserved bits not zero");
	chk_ns_no_preempt: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!bf_ns |=> !hf_preempt_ns_o) else $error("non-secure hard fault preempted");
	chk_state_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr && hit_state && !ns_acc |=> (sec_b.rd_data & impl) == ($past(pwdata) & impl)) else $error("write lost");
	chk_shared_copy: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		((sec_b.rd_data ^ rd_view) & `M_SHARED & impl & ~((ns_acc & ~bf_ns) ? `M_BUS : 32'h0)) == 32'h0)
		else $error("shared bit mismatch");
	chk_ns_bank_only: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		ns_b.wr_en |=> ((ns_b.rd_data ^ $past(ns_b.rd_data)) & `M_SHARED) == 32'h0) else $error("ns copy touched shared");

	// ********************
	// bus, banking and event checks
	// ********************
	// the setup phase of a read, and a state write from either side;
	// banking checks hold each copy against its own value one cycle earlier
	sequence seq_read_setup;
		psel && !penable && !pwrite && hit_state;
	endsequence
	sequence seq_sec_state_wr;
		wr && hit_state && !ns_acc;
	endsequence
	sequence seq_ns_state_wr;
		wr && hit_state && ns_acc;
	endsequence
	sequence seq_hidden_bus_wr;
		seq_ns_state_wr ##0 !bf_ns;
	endsequence

	// read data are taken in the setup cycle so they stand through the access phase
	chk_read_capture: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		seq_read_setup |=> prdata == $past(rd_view)) else $error("read data not captured");

	// a non-secure write must not reach bus fault bits that are not delegated
	chk_bus_write_ignored: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		seq_hidden_bus_wr |=> ((sec_b.rd_data ^ $past(sec_b.rd_data)) & `M_BUS) == 32'h0) else $error("bus bit written");

	// a non-secure write leaves the secure banked bits alone
	chk_sec_bank_kept: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		seq_ns_state_wr |=> ((sec_b.rd_data ^ $past(sec_b.rd_data)) & ~`M_SHARED) == 32'h0) else $error("secure copy hit");

	// a secure write leaves the non-secure copy alone
	chk_ns_bank_kept: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		seq_sec_state_wr |=> $stable(ns_b.rd_data)) else $error("non-secure copy hit");

	// the non-secure write lands in its own copy
	chk_ns_write_lands: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		seq_ns_state_wr |=> ((ns_b.rd_data ^ $past(pwdata)) & $past(ns_b.wr_keep)) == 32'h0) else $error("ns write lost");

	// partial strobes are refused rather than merged, so no byte lane update exists
	chk_partial_ignored: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		acc && pwrite && !(&pstrb) |=> $stable(sec_b.rd_data) && $stable(ns_b.rd_data)) else $error("partial write landed");

	// unmapped writes change no register
	chk_unmapped_ignored: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr && !hit_any |=> $stable(cfg_q) && $stable(mask_q) && $stable(sec_b.rd_data)) else $error("unmapped write landed");

	// the delegation setting belongs to the secure side only
	chk_cfg_guarded: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr && hit_cfg && ns_acc |=> $stable(cfg_q)) else $error("non-secure changed config");

	chk_cfg_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr && hit_cfg && !ns_acc |=> cfg_q == $past(pwdata[1:0])) else $error("config write lost");

	// escalation leaves a sticky event; set wins over a clear in the same cycle
	chk_escalate_event: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		fault_valid_i && !en_bit |=> evt_q[0]) else $error("escalation event lost");

	chk_event_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr && hit_evt && pwdata[0] && !(fault_valid_i && !en_bit) |=> !evt_q[0]) else $error("event not cleared");

	chk_evt_sticky: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		evt_q[0] && !(wr && hit_evt && pwdata[0]) |=> evt_q[0]) else $error("event dropped");

	chk_mask_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr && hit_mask |=> mask_q == $past(pwdata[1:0])) else $error("mask write lost");

	// a blocked non-secure hard fault is reported as an event
	chk_block_event: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		sec_ext && !bf_ns && ns_b.rd_data[`B_HF_PEND] |=> evt_q[1]) else $error("blocked event lost");

	chk_ns_preempt_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		sec_ext && bf_ns && ns_b.rd_data[`B_HF_PEND] |=> hf_preempt_ns_o) else $error("delegated hard fault held");

	chk_preempt_secure: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		sec_b.rd_data[`B_HF_PEND] |=> hf_preempt_s_o) else $error("secure hard fault held");

	// kind follows the fault that was taken
	chk_take_kind: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		fault_valid_i && en_bit |=> fault_take_kind_o == $past(fault_kind_i)) else $error("taken kind wrong");

	chk_take_exclusive: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!(fault_take_o && hard_fault_o)) else $error("fault both taken and escalated");

	chk_idle_quiet: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!fault_valid_i |=> !fault_take_o && !hard_fault_o) else $error("fault output without report");

	// without the extension the secure fault bits stay hidden
	chk_sec_only_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!sec_ext |-> (rd_view & `M_SEC_ONLY) == 32'h0) else $error("secure fault bits visible");
endmodule

// File: tb/system_handler_control_state_test.sv
`timescale 1ns/1ps
`include "shcs_defs.svh"
module system_handler_control_state_test import shcs_pkg::*;;
	logic ref_clk_i, reset_i, psel, penable, pwrite, fault_valid_i, fault_secure_i;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, s, nsv, cm, rd;
	logic [3:0] pstrb;
	logic [2:0] pprot;
	logic pready, pslverr, fault_take_o, hard_fault_o, hf_preempt_s_o, hf_preempt_ns_o, irq_o, err;
	logic [1:0] cfg, ev, mask;
	fault_kind_t fault_kind_i, fault_take_kind_o;
	int failures = 0;
	int num_checks = 0;
	localparam logic [31:0] bank_m = `M_IMPL & ~`M_SHARED;
	system_handler_control_state DUT (.ref_clk_i, .reset_i, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.pprot, .prdata, .pready, .pslverr, .fault_valid_i, .fault_kind_i, .fault_secure_i, .fault_take_o,
		.fault_take_kind_o, .hard_fault_o, .hf_preempt_s_o, .hf_preempt_ns_o, .irq_o);
	// 250 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	// ****************************************
	// bus tasks and reference model
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if ((g & cm) !== (e & cm)) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one apb transfer; request held until pready is seen high or 16 access cycles pass
	task automatic apb(input logic w, input logic n, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge ref_clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pprot <= {1'b0, n, 1'b0};
		@(posedge ref_clk_i);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk_i);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// model follows every write; non-secure view keeps its own banked copy
	task automatic wr(input logic n, input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, n, a, d);
		if (pstrb !== 4'hF) return;
		case (a)
			`SHCS_OFF_STATE: if (n && cfg[1]) begin
				nsv = d & bank_m;
				if (cfg[0]) s = (s & ~`M_BUS) | (d & `M_BUS);
			end else s = d & (cfg[1] ? `M_IMPL : `M_IMPL & ~`M_SEC_ONLY);
			`SHCS_OFF_CFG: if (!(n && cfg[1])) cfg = d[1:0];
			`SHCS_OFF_EVT: ev = ev & ~d[1:0];
			`SHCS_OFF_MASK: mask = d[1:0];
			default: ;
		endcase
	endtask
	task automatic rdc(input logic n, input logic [11:0] a);
		logic [31:0] e;
		apb(1'b0, n, a, 32'h0);
		case (a)
			`SHCS_OFF_STATE: e = (n && cfg[1]) ? (nsv & bank_m) | (cfg[0] ? s & `M_BUS : 32'h0) : s;
			`SHCS_OFF_CFG: e = {30'h0, cfg};
			`SHCS_OFF_EVT: e = {30'h0, ev};
			`SHCS_OFF_MASK: e = {30'h0, mask};
			default: e = 32'h0;
		endcase
		chk("prdata", e, rd);
		chk("pslverr", {31'h0, a > 12'h00C}, {31'h0, err});
		chk("pready", 32'h1, {31'h0, pready});
		chk("irq_o", {31'h0, |(ev & mask)}, {31'h0, irq_o});
	endtask
	// a disabled handler must send the fault on as an escalation
	task automatic flt(input logic [1:0] k);
		logic en;
		en = s[16 + k];
		@(posedge ref_clk_i);
		fault_valid_i <= 1'b1;
		fault_kind_i <= fault_kind_t'(k);
		fault_secure_i <= 1'b1;
		@(posedge ref_clk_i);
		fault_valid_i <= 1'b0;
		#1;
		chk("fault_take_o", {31'h0, en}, {31'h0, fault_take_o});
		chk("hard_fault_o", {31'h0, ~en}, {31'h0, hard_fault_o});
		if (en) chk("fault_take_kind_o", {30'h0, k}, {30'h0, fault_take_kind_o});
		ev[0] = ev[0] | ~en;
	endtask
	task automatic rst();
		@(posedge ref_clk_i);
		reset_i <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		s = 32'h0;
		nsv = 32'h0;
		cfg = 2'h0;
		ev = 2'h0;
		mask = 2'h0;
		cm = 32'hFFFFFFFF;
	endtask
	task automatic final_report();
		if (failures == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog: far beyond the roughly 170 cycles the sequence needs
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		failures++;
		final_report();
	end
	// main sequence
	initial begin
		logic [31:0] r;
		int i;
		{psel, penable, pwrite, fault_valid_i, fault_secure_i, reset_i} = 6'h01;
		{paddr, pwdata, pprot} = 47'h0;
		pstrb = 4'hF;
		fault_kind_i = F_MEM;
		void'($urandom(32'h0488));
		rst();
		rdc(1'b0, `SHCS_OFF_STATE);
		for (i = 0; i < 6; i++) begin
			r = (i == 0) ? 32'hFFFFFFFF : $urandom;
			wr(1'b0, `SHCS_OFF_STATE, r);
			rdc(1'b0, `SHCS_OFF_STATE);
		end
		pstrb <= 4'h7;
		wr(1'b0, `SHCS_OFF_STATE, 32'h0);
		pstrb <= 4'hF;
		rdc(1'b0, `SHCS_OFF_STATE);
		wr(1'b0, 12'h010, 32'hFFFFFFFF);
		rdc(1'b0, 12'h010);
		for (i = 0; i < 8; i++) begin
			if (i % 4 == 0) wr(1'b0, `SHCS_OFF_STATE, (i < 4) ? 32'h0 : 32'h00070000);
			flt(i[1:0]);
		end
		rdc(1'b0, `SHCS_OFF_STATE);
		wr(1'b0, `SHCS_OFF_STATE, rd | 32'h00000800);
		rdc(1'b0, `SHCS_OFF_STATE);
		rdc(1'b0, `SHCS_OFF_EVT);
		wr(1'b0, `SHCS_OFF_MASK, 32'h3);
		rdc(1'b0, `SHCS_OFF_EVT);
		wr(1'b0, `SHCS_OFF_EVT, 32'h1);
		rdc(1'b0, `SHCS_OFF_EVT);
		// second reset, then the banked view with the extension present
		rst();
		wr(1'b0, `SHCS_OFF_CFG, 32'h2);
		wr(1'b0, `SHCS_OFF_STATE, 32'hFFFFFFFF);
		rdc(1'b0, `SHCS_OFF_STATE);
		cm = ~(`M_SHARED & ~`M_BUS);
		wr(1'b1, `SHCS_OFF_STATE, 32'h0);
		rdc(1'b1, `SHCS_OFF_STATE);
		rdc(1'b0, `SHCS_OFF_STATE);
		wr(1'b1, `SHCS_OFF_STATE, $urandom | 32'h00200000);
		rdc(1'b1, `SHCS_OFF_STATE);
		rdc(1'b0, `SHCS_OFF_STATE);
		wr(1'b1, `SHCS_OFF_CFG, 32'h1);
		rdc(1'b0, `SHCS_OFF_CFG);
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk("hf_preempt_s_o", 32'h1, {31'h0, hf_preempt_s_o});
		chk("hf_preempt_ns_o", 32'h0, {31'h0, hf_preempt_ns_o});
		ev[1] = 1'b1;
		rdc(1'b0, `SHCS_OFF_EVT);
		wr(1'b0, `SHCS_OFF_CFG, 32'h3);
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk("hf_preempt_ns_o", 32'h1, {31'h0, hf_preempt_ns_o});
		wr(1'b1, `SHCS_OFF_STATE, 32'h0);
		rdc(1'b1, `SHCS_OFF_STATE);
		rdc(1'b0, `SHCS_OFF_STATE);
		wr(1'b0, `SHCS_OFF_EVT, 32'h3);
		rdc(1'b0, `SHCS_OFF_EVT);
		final_report();
	end
endmodule
